/* File: isf_map.svh */
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

// Register byte offsets
`define ISF_OFS_CFG      8'h00
`define ISF_OFS_STA      8'h04
`define ISF_OFS_RXD      8'h08
`define ISF_OFS_TXD      8'h0c
`define ISF_OFS_ADDR     8'h10
`define ISF_OFS_IRQ_STA  8'h14
`define ISF_OFS_IRQ_CLR  8'h18
`define ISF_OFS_IRQ_EN   8'h1c

// Config fields
`define ISF_CFG_EN       0
`define ISF_CFG_RXFLUSH  1
`define ISF_CFG_TXFLUSH  2
`define ISF_CFG_GCEN     3
`define ISF_CFG_GCCLR    8

// Status fields
`define ISF_STA_TXNF     0
`define ISF_STA_TXUF     1
`define ISF_STA_TXIRQ    2
`define ISF_STA_RXIRQ    3
`define ISF_STA_RXOVF    4
`define ISF_STA_NACK     5
`define ISF_STA_BUSY     6
`define ISF_STA_GC       7

// Interrupt event fields
`define ISF_EV_GC        0
`define ISF_EV_NACK      1
`define ISF_EV_RXOVF     2
`define ISF_EV_RXBYTE    3
`define ISF_EV_TXDONE    4
`define ISF_EV_TXUF      5
`define ISF_EV_W         6

// Reset values and bus constants
`define ISF_CFG_RST      2'b00
`define ISF_ADDR_RST     7'h50
`define ISF_IRQ_EN_RST   6'h00
`define ISF_GC_RST_BYTE  8'h06
`define ISF_TX_IDLE_BYTE 8'hff
`define ISF_BYTE_BITS    4'h8

`endif

/* File: isf_pkg.sv */
`default_nettype none

package isf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX   = 3'b011,
    ST_RACK = 3'b100,
    ST_TX   = 3'b101,
    ST_MACK = 3'b110,
    ST_SKIP = 3'b111
  } isf_state_t;

endpackage : isf_pkg

`default_nettype wire

/* File: isf_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module isf_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : isf_sync

`default_nettype wire

/* File: isf_fifo_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module isf_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  output logic                  empty,
  output logic                  full
);

  localparam int AW = $clog2(DEPTH);

  // Pointers wrap by overflow, so only powers of two work
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("isf_fifo_mem: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW-1:0]    rp_d;
  logic [AW:0]      cnt_q;
  logic             do_push;
  logic             do_pop;

  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign empty   = (cnt_q == '0);
  assign full    = (cnt_q == (AW+1)'(DEPTH));
  assign rp_d    = flush ? '0 : (do_pop ? rp_q + 1'b1 : rp_q);

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_q[wp_q] <= wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      rp_q <= rp_d;
      if (do_push)
        wp_q <= wp_q + 1'b1;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Look-ahead read so the head word is ready the cycle after a pop
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (do_push && wp_q == rp_d)
      rdata <= wdata;
    else
      rdata <= mem_q[rp_d];
  end

endmodule : isf_fifo_mem

`default_nettype wire

/* File: isf_top.sv */
// Notes on behaviour
// - General call flag held until config bit8
// - General call reset restores every register default
// - Hardware general call second byte enters receive FIFO
// - Busy follows slave engagement in transfer
// - Read request without data sets no-ack
// - Byte into full receive FIFO sets overflow
// - Received byte sets rx flag; read clears
// - Transmission end sets tx flag; write clears
// - Read from empty tx FIFO sets underflow
// - Tx not-full shows a free entry
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.svh"

module isf_top
  import isf_pkg::*;
#(
  parameter int RX_DEPTH = 4,
  parameter int TX_DEPTH = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output logic             irq
);

  logic                   scl_s;
  logic                   sda_s;
  logic                   scl_d_q;
  logic                   sda_d_q;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_start;
  logic                   bus_stop;
  logic                   setup;
  logic                   done;
  logic                   mapped;
  logic                   wr_cfg;
  logic                   wr_sta;
  logic                   wr_txd;
  logic                   wr_addr;
  logic                   wr_iclr;
  logic                   wr_ien;
  logic                   rd_sta;
  logic                   rd_rxd;
  logic [1:0]             cfg_q;
  logic [6:0]             addr_q;
  logic [`ISF_EV_W-1:0]   ien_q;
  logic [`ISF_EV_W-1:0]   ists_q;
  logic [`ISF_EV_W-1:0]   evt;
  logic                   gc_flag_q;
  logic                   nack_q;
  logic                   rxovf_q;
  logic                   rxirq_q;
  logic                   txirq_q;
  logic                   txuf_q;
  logic                   txnf_q;
  logic                   busy_q;
  logic [7:0]             sta;
  logic                   rx_flush;
  logic                   tx_flush;
  logic                   rx_push_q;
  logic                   tx_pop_q;
  logic [7:0]             rx_rdata;
  logic [7:0]             tx_rdata;
  logic                   rx_empty;
  logic                   rx_full;
  logic                   tx_empty;
  logic                   tx_full;
  logic                   gc_rst_q;
  isf_state_t             st_q;
  logic [3:0]             cnt_q;
  logic [7:0]             sh_q;
  logic                   rw_q;
  logic                   gc_first_q;
  logic                   rst_pend_q;
  logic                   drive_q;
  logic                   ev_gc_q;
  logic                   ev_nack_q;
  logic                   ev_ovf_q;
  logic                   ev_rx_q;
  logic                   ev_txd_q;
  logic                   ev_uf_q;
  logic                   own_hit;
  logic                   gc_hit;

  isf_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (scl_in),
    .q     (scl_s)
  );

  isf_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (sda_in),
    .q     (sda_s)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d_q;
  assign scl_fall  = !scl_s && scl_d_q;
  assign bus_start = scl_s && scl_d_q && sda_d_q && !sda_s;
  assign bus_stop  = scl_s && scl_d_q && !sda_d_q && sda_s;

  // Register access decode
  assign setup   = psel && !penable;
  assign done    = psel && penable && pready;
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `ISF_OFS_IRQ_EN);
  assign wr_cfg  = done && pwrite && paddr == `ISF_OFS_CFG;
  assign wr_sta  = done && pwrite && paddr == `ISF_OFS_STA;
  assign wr_txd  = done && pwrite && paddr == `ISF_OFS_TXD;
  assign wr_addr = done && pwrite && paddr == `ISF_OFS_ADDR;
  assign wr_iclr = done && pwrite && paddr == `ISF_OFS_IRQ_CLR;
  assign wr_ien  = done && pwrite && paddr == `ISF_OFS_IRQ_EN;
  assign rd_sta  = done && !pwrite && paddr == `ISF_OFS_STA;
  assign rd_rxd  = done && !pwrite && paddr == `ISF_OFS_RXD;

  assign rx_flush = gc_rst_q || (wr_cfg && pwdata[`ISF_CFG_RXFLUSH]);
  assign tx_flush = gc_rst_q || (wr_cfg && pwdata[`ISF_CFG_TXFLUSH]);

  assign sta = {gc_flag_q, busy_q, nack_q, rxovf_q,
                rxirq_q, txirq_q, txuf_q, txnf_q};

  // No wait states: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
      begin
        unique case (paddr)
          `ISF_OFS_CFG:     prdata <= {30'h0, cfg_q};
          `ISF_OFS_STA:     prdata <= {24'h0, sta};
          `ISF_OFS_RXD:     prdata <= {24'h0, rx_rdata};
          `ISF_OFS_ADDR:    prdata <= {25'h0, addr_q};
          `ISF_OFS_IRQ_STA: prdata <= {26'h0, ists_q};
          `ISF_OFS_IRQ_EN:  prdata <= {26'h0, ien_q};
          default:          prdata <= '0;
        endcase
      end
      // Zero outside a read answer, so refused writes return no data
      else
        prdata <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q  <= `ISF_CFG_RST;
      addr_q <= `ISF_ADDR_RST;
      ien_q  <= `ISF_IRQ_EN_RST;
    end
    else if (gc_rst_q)
    begin
      cfg_q  <= `ISF_CFG_RST;
      addr_q <= `ISF_ADDR_RST;
      ien_q  <= `ISF_IRQ_EN_RST;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= {pwdata[`ISF_CFG_GCEN], pwdata[`ISF_CFG_EN]};
      if (wr_addr)
        addr_q <= pwdata[6:0];
      if (wr_ien)
        ien_q <= pwdata[`ISF_EV_W-1:0];
    end
  end

  // Status flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gc_flag_q <= 1'b0;
      nack_q    <= 1'b0;
      rxovf_q   <= 1'b0;
      rxirq_q   <= 1'b0;
      txirq_q   <= 1'b0;
      txuf_q    <= 1'b0;
      txnf_q    <= 1'b0;
    end
    else if (gc_rst_q)
    begin
      gc_flag_q <= 1'b0;
      nack_q    <= 1'b0;
      rxovf_q   <= 1'b0;
      rxirq_q   <= 1'b0;
      txirq_q   <= 1'b0;
      txuf_q    <= 1'b0;
      txnf_q    <= 1'b0;
    end
    else
    begin
      gc_flag_q <= ev_gc_q ||
                   (gc_flag_q && !(wr_cfg && pwdata[`ISF_CFG_GCCLR]));
      // Only bits seen by the read are cleared
      nack_q  <= ev_nack_q ||
                 (nack_q && !(rd_sta && prdata[`ISF_STA_NACK]));
      rxovf_q <= ev_ovf_q ||
                 (rxovf_q && !(rd_sta && prdata[`ISF_STA_RXOVF]));
      rxirq_q <= ev_rx_q || (rxirq_q && !(rd_rxd || rx_flush));
      txirq_q <= ev_txd_q || (txirq_q && !wr_txd);
      txuf_q  <= ev_uf_q || (txuf_q && !wr_sta);
      txnf_q  <= !tx_full;
    end
  end

  // Interrupt: sticky status, write-one clear, enable mask
  assign evt = {ev_uf_q, ev_txd_q, ev_rx_q, ev_ovf_q, ev_nack_q, ev_gc_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ists_q <= '0;
      irq    <= 1'b0;
    end
    else if (gc_rst_q)
    begin
      ists_q <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      ists_q <= evt | (ists_q & ~(wr_iclr ? pwdata[`ISF_EV_W-1:0] : '0));
      irq    <= |(ists_q & ien_q);
    end
  end

  isf_fifo_mem #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .flush (rx_flush),
    .push  (rx_push_q),
    .wdata (sh_q),
    .pop   (rd_rxd),
    .rdata (rx_rdata),
    .empty (rx_empty),
    .full  (rx_full)
  );

  // Writes to a full transmit FIFO are dropped
  isf_fifo_mem #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .flush (tx_flush),
    .push  (wr_txd),
    .wdata (pwdata[7:0]),
    .pop   (tx_pop_q),
    .rdata (tx_rdata),
    .empty (tx_empty),
    .full  (tx_full)
  );

  assign own_hit = cfg_q[0] && sh_q[7:1] == addr_q;
  assign gc_hit  = cfg_q[0] && cfg_q[1] && sh_q == 8'h00;

  // Serial engine; shifted byte stays in sh_q while pushed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= ST_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      rw_q       <= 1'b0;
      gc_first_q <= 1'b0;
      rst_pend_q <= 1'b0;
      drive_q    <= 1'b0;
      busy_q     <= 1'b0;
      gc_rst_q   <= 1'b0;
      rx_push_q  <= 1'b0;
      tx_pop_q   <= 1'b0;
      ev_gc_q    <= 1'b0;
      ev_nack_q  <= 1'b0;
      ev_ovf_q   <= 1'b0;
      ev_rx_q    <= 1'b0;
      ev_txd_q   <= 1'b0;
      ev_uf_q    <= 1'b0;
    end
    else
    begin
      gc_rst_q  <= 1'b0;
      rx_push_q <= 1'b0;
      tx_pop_q  <= 1'b0;
      ev_gc_q   <= 1'b0;
      ev_nack_q <= 1'b0;
      ev_ovf_q  <= 1'b0;
      ev_rx_q   <= 1'b0;
      ev_txd_q  <= 1'b0;
      ev_uf_q   <= 1'b0;
      if (gc_rst_q)
      begin
        st_q       <= ST_IDLE;
        drive_q    <= 1'b0;
        busy_q     <= 1'b0;
        rst_pend_q <= 1'b0;
        gc_first_q <= 1'b0;
      end
      else if (bus_start)
      begin
        st_q    <= ST_ADDR;
        cnt_q   <= '0;
        drive_q <= 1'b0;
        busy_q  <= 1'b0;
      end
      else if (bus_stop)
      begin
        st_q    <= ST_IDLE;
        drive_q <= 1'b0;
        busy_q  <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          ST_IDLE, ST_SKIP:
          begin
            drive_q <= 1'b0;
            busy_q  <= 1'b0;
          end
          ST_ADDR, ST_RX:
          begin
            if (scl_rise && cnt_q != `ISF_BYTE_BITS)
            begin
              sh_q  <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && cnt_q == `ISF_BYTE_BITS)
            begin
              cnt_q <= '0;
              if (st_q == ST_ADDR)
              begin
                if (own_hit && sh_q[0] && tx_empty)
                begin
                  ev_nack_q <= 1'b1;
                  st_q      <= ST_SKIP;
                end
                else if (own_hit || gc_hit)
                begin
                  drive_q    <= 1'b1;
                  busy_q     <= 1'b1;
                  rw_q       <= sh_q[0];
                  gc_first_q <= gc_hit;
                  ev_gc_q    <= gc_hit;
                  st_q       <= ST_AACK;
                end
                else
                  st_q <= ST_SKIP;
              end
              else
              begin
                st_q       <= ST_RACK;
                gc_first_q <= 1'b0;
                if (gc_first_q && sh_q == `ISF_GC_RST_BYTE)
                begin
                  drive_q    <= 1'b1;
                  rst_pend_q <= 1'b1;
                end
                else if (gc_first_q && !sh_q[0])
                  drive_q <= 1'b1;
                else if (rx_full)
                  ev_ovf_q <= 1'b1;
                else
                begin
                  drive_q   <= 1'b1;
                  rx_push_q <= 1'b1;
                  ev_rx_q   <= 1'b1;
                end
              end
            end
          end
          ST_AACK:
          begin
            if (scl_fall && rw_q)
            begin
              sh_q     <= tx_rdata;
              tx_pop_q <= 1'b1;
              drive_q  <= !tx_rdata[7];
              st_q     <= ST_TX;
            end
            else if (scl_fall)
            begin
              drive_q <= 1'b0;
              st_q    <= ST_RX;
            end
          end
          ST_RACK:
          begin
            if (scl_fall)
            begin
              drive_q  <= 1'b0;
              st_q     <= ST_RX;
              gc_rst_q <= rst_pend_q;
            end
          end
          ST_TX:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall && cnt_q == `ISF_BYTE_BITS)
            begin
              cnt_q   <= '0;
              drive_q <= 1'b0;
              st_q    <= ST_MACK;
            end
            else if (scl_fall)
            begin
              sh_q    <= {sh_q[6:0], 1'b1};
              drive_q <= !sh_q[6];
            end
          end
          ST_MACK:
          begin
            if (scl_rise && sda_s)
            begin
              ev_txd_q <= 1'b1;
              st_q     <= ST_SKIP;
            end
            else if (scl_rise)
              cnt_q <= 4'h1;
            else if (scl_fall && cnt_q == 4'h1)
            begin
              cnt_q <= '0;
              st_q  <= ST_TX;
              if (tx_empty)
              begin
                ev_uf_q <= 1'b1;
                sh_q    <= `ISF_TX_IDLE_BYTE;
                drive_q <= 1'b0;
              end
              else
              begin
                sh_q     <= tx_rdata;
                tx_pop_q <= 1'b1;
                drive_q  <= !tx_rdata[7];
              end
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out  <= 1'b0;
      sda_oe_n <= !drive_q;
    end
  end

endmodule : isf_top

`default_nettype wire

/* File: isf_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.svh"

module isf_top_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence one_ready_s;
    pready ##1 !pready;
  endsequence
  sequence acc_s;
    psel && penable && pready;
  endsequence

  answer_in_time_a: assert property (setup_s |=> one_ready_s)
    else $error("pready not one cycle after setup");
  ready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr alone or with data");
  unmapped_err_a: assert property (setup_s ##0
      (paddr > `ISF_OFS_IRQ_EN || paddr[1:0] != 2'b00) |=> pslverr)
    else $error("unmapped address not refused");
  wo_read_zero_a: assert property (acc_s ##0 !pwrite ##0
      (paddr == `ISF_OFS_TXD || paddr == `ISF_OFS_IRQ_CLR) |-> prdata == 0)
    else $error("write-only register read nonzero");
  sda_open_drain_a: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  // Slave only moves SDA while SCL is low, else it fakes START or STOP
  oe_on_low_a: assert property ($changed(sda_oe_n) |-> !$past(scl_in, 3))
    else $error("sda enable changed with scl high");
  irq_masked_a: assert property (acc_s ##0 pwrite ##0
      (paddr == `ISF_OFS_IRQ_EN && pwdata[5:0] == 6'h00) |-> ##2 !irq)
    else $error("irq high with all sources masked");
endmodule : isf_top_chk

bind isf_top isf_top_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq)
);

`default_nettype wire

/* File: isf_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus master; SCL stands high between frames, 8 pclk per bit
module isf_i2c_master (
  input  wire logic pclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // Starts with a wait so no signal is set twice in one step
  task automatic start();
    wt(2);
    sda_drv <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_drv <= 1'b0;
    wt(4);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    wt(2);
    sda_drv <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_drv <= 1'b1;
    wt(4);
  endtask : stop

  // SDA moves mid-low; sampled at the end of the high phase
  task automatic bit1(input logic b, output logic r);
    wt(2);
    sda_drv <= b;
    wt(2);
    scl <= 1'b1;
    wt(4);
    r = sda_line;
    scl <= 1'b0;
  endtask : bit1

  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] q, output logic ao);
    logic x;
    for (int i = 7; i >= 0; i--)
    begin
      bit1(d[i], x);
      q[i] = x;
    end
    bit1(ai, ao);
  endtask : xfer
endmodule : isf_i2c_master

`default_nettype wire

/* File: i2c_slave_status_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "isf_map.svh"
`define CHK(n, g, e) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end

module i2c_slave_status_flags_tb_top;
  localparam int DEPTH = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [7:0]  b;
  logic        pready, pslverr, sda_out, sda_oe_n, irq;
  logic        scl, m_sda, sda_line, a, err;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;

  // Open drain with pull-up: low if either side pulls
  assign sda_line = m_sda & (sda_oe_n | sda_out);
  always #25 pclk = ~pclk;

  isf_top #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq)
  );
  isf_i2c_master m_u (
    .pclk(pclk), .sda_line(sda_line), .scl(scl), .sda_drv(m_sda)
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is seen high; the bench timeout catches a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e,
                     input string nm);
    apb(1'b0, ad, 32'h0, r);
    `CHK(nm, r, e)
  endtask : rdc

  // Flags land a few pclk after the SCL edge is synchronised
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask : settle

  task automatic wb(input logic [7:0] d, input logic ea);
    m_u.xfer(d, 1'b1, b, a);
    `CHK("slave ack", a, ea)
    settle();
  endtask : wb

  task automatic irqc(input logic e);
    settle();
    `CHK("irq", irq, e)
  endtask : irqc

  task automatic stp();
    m_u.stop();
    settle();
  endtask : stp

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(`ISF_OFS_STA, 32'h01, "sta reset");
    rdc(`ISF_OFS_ADDR, 32'h50, "addr reset");
    apb(1'b0, 8'h20, 32'h0, r);
    `CHK("unmapped", err, 1'b1)
    wr(8'h06, 32'h0);
    `CHK("misaligned write", err, 1'b1)
    rdc(`ISF_OFS_TXD, 32'h0, "txd write only");
    rdc(`ISF_OFS_IRQ_CLR, 32'h0, "irq clr write only");
    $display("test reset done");
    wr(`ISF_OFS_CFG, 32'h1);
    wr(`ISF_OFS_IRQ_EN, 32'h3f);
    m_u.start();
    wb(8'ha0, 1'b0);
    rdc(`ISF_OFS_STA, 32'h41, "busy");
    wb(8'ha5, 1'b0);
    rdc(`ISF_OFS_STA, 32'h49, "rx flag");
    irqc(1'b1);
    wr(`ISF_OFS_IRQ_EN, 32'h0);
    irqc(1'b0);
    wr(`ISF_OFS_IRQ_EN, 32'h3f);
    irqc(1'b1);
    stp();
    rdc(`ISF_OFS_STA, 32'h09, "busy off");
    rdc(`ISF_OFS_RXD, 32'ha5, "rx data");
    rdc(`ISF_OFS_STA, 32'h01, "rx flag clr");
    rdc(`ISF_OFS_IRQ_STA, 32'h08, "irq sta");
    wr(`ISF_OFS_IRQ_CLR, 32'h3f);
    irqc(1'b0);
    $display("test rx done");
    m_u.start();
    wb(8'ha0, 1'b0);
    for (int i = 0; i < DEPTH; i++)
      wb(8'h10 + i, 1'b0);
    wb(8'h14, 1'b1);
    stp();
    rdc(`ISF_OFS_STA, 32'h19, "overflow");
    rdc(`ISF_OFS_STA, 32'h09, "ovf clr");
    wr(`ISF_OFS_CFG, 32'h3);
    rdc(`ISF_OFS_STA, 32'h01, "flush clr");
    $display("test overflow done");
    for (int i = 0; i < DEPTH; i++)
    begin
      wr(`ISF_OFS_TXD, 32'hc0 + i);
      apb(1'b0, `ISF_OFS_STA, 32'h0, r);
      `CHK("tx not full", r[`ISF_STA_TXNF], i < DEPTH - 1)
    end
    m_u.start();
    wb(8'ha1, 1'b0);
    for (int i = 0; i < DEPTH; i++)
    begin
      m_u.xfer(8'hff, 1'b0, b, a);
      `CHK("tx byte", b, 8'hc0 + i)
    end
    m_u.xfer(8'hff, 1'b1, b, a);
    `CHK("idle byte", b, 8'hff)
    stp();
    rdc(`ISF_OFS_STA, 32'h07, "uf and tx flag");
    wr(`ISF_OFS_STA, 32'h0);
    rdc(`ISF_OFS_STA, 32'h05, "uf clr");
    wr(`ISF_OFS_TXD, 32'h11);
    rdc(`ISF_OFS_STA, 32'h01, "tx flag clr");
    wr(`ISF_OFS_CFG, 32'h5);
    m_u.start();
    wb(8'ha1, 1'b1);
    stp();
    rdc(`ISF_OFS_STA, 32'h21, "no ack");
    rdc(`ISF_OFS_STA, 32'h01, "no ack clr");
    $display("test tx done");
    wr(`ISF_OFS_CFG, 32'h9);
    m_u.start();
    wb(8'h00, 1'b0);
    wb(8'h0b, 1'b0);
    stp();
    rdc(`ISF_OFS_STA, 32'h89, "gc flag");
    rdc(`ISF_OFS_RXD, 32'h0b, "gc byte");
    rdc(`ISF_OFS_STA, 32'h81, "gc held");
    wr(`ISF_OFS_CFG, 32'h109);
    rdc(`ISF_OFS_STA, 32'h01, "gc clr");
    wr(`ISF_OFS_ADDR, 32'h33);
    m_u.start();
    wb(8'h00, 1'b0);
    wb(8'h06, 1'b0);
    stp();
    rdc(`ISF_OFS_ADDR, 32'h50, "soft addr");
    rdc(`ISF_OFS_CFG, 32'h0, "soft cfg");
    rdc(`ISF_OFS_IRQ_EN, 32'h0, "soft irq en");
    rdc(`ISF_OFS_STA, 32'h01, "soft sta");
    irqc(1'b0);
    $display("test general call done");
    close_out();
  end
endmodule : i2c_slave_status_flags_tb_top

`default_nettype wire
